/* cics_pkg.sv */
/*
  cics_pkg: shared constants for the configuration init/chain sequencer.
  assumes a single 10 MHz pclk domain on both ends.
*/
package cics_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned INIT_CYCLES = 299;
  localparam int unsigned USR_CLK_MAX_MHZ = 100;
  localparam int unsigned RECONF_LOW_NS = 2000;
  localparam int unsigned RECONF_LOW_CYC = (RECONF_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RESTART_TMO_NS = 40000;
  localparam int unsigned RESTART_TMO_CYC = (RESTART_TMO_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned CS_PULSE_CYC = 2;
  localparam int unsigned CNT_W = 16;
  // ----------------------------------------------------------------
  // scheme select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SCHEME_ACTIVE = 2'h0;
  localparam logic [1:0] SCHEME_PASSIVE = 2'h1;
  // ----------------------------------------------------------------
  // apb register map of the controller
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int unsigned CTRL_RECONF = 0;
  localparam int unsigned CTRL_USRCLK_RUN = 1;
  localparam int unsigned STAT_STATUS = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_INIT_DONE = 2;
  localparam int unsigned STAT_RECONF_BUSY = 3;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_LOAD = 6'h02,
    ST_WAIT_DONE = 6'h04,
    ST_INIT = 6'h08,
    ST_USER = 6'h10,
    ST_ERROR = 6'h20
  } cics_state_t;
endpackage

/* cics_link_if.sv */
/*
  cics_link_if: pins between a configuring device and its controller.
  open-drain lines resolve here from the output enables (pull-up implied).
*/
`timescale 1ns/1ps
interface cics_link_if;
  logic reconf_req_n;
  logic usr_clk;
  logic status_oe;
  logic done_oe;
  logic status_ext_oe;
  logic done_ext_oe;
  logic init_done_oe;
  logic chain_enable_in_n;
  logic chain_enable_out_n;
  logic flash_cs_n;
  logic status_line;
  logic done_line;
  logic init_done_line;
  // ----------------------------------------------------------------
  // wired-and of the shared lines
  // ----------------------------------------------------------------
  assign status_line = ~(status_oe | status_ext_oe);
  assign done_line = ~(done_oe | done_ext_oe);
  assign init_done_line = ~init_done_oe;

  modport dev (
    input reconf_req_n, usr_clk, status_line, done_line, chain_enable_in_n,
    output status_oe, done_oe, init_done_oe, chain_enable_out_n, flash_cs_n
  );
  modport ctl (
    input status_line, done_line, init_done_line, chain_enable_out_n, flash_cs_n,
    output reconf_req_n, usr_clk, status_ext_oe, done_ext_oe, chain_enable_in_n
  );
endinterface

/* cics_device.sv */
/*
  cics_device: load completion, init count, user mode, error restart and chain hand-off.
  assumes the external controller keeps its own timing on reconfigure and user clock.
*/
// The APB register port and the register offsets were chosen for this implementation.
// Function
// - init clock internal unless user clock enabled
// - 299 init cycles after done high
// - no user mode while user clock withheld
// - loading independent of user clock
// - init-done low from first frame, released after
// - user mode drops pull-ups, enables user pins
// - reconfigure request held low two microseconds
// - request low: reset, status/done low, tri-state
// - reload after request high and status released
// - frame error: status low, done low
// - auto-restart: cs pulse, 40 us, retry
// - no auto-restart: host watches status, reconfigures
// - host keeps user clock during status low
// - all own data captured: chain-out low
// - chain-out driven to ground after load
// - first device master, active serial scheme
// - shared open-drain lines, common init start
// - host orders user entry by user clocks
// - any error pulls status, chain reloads
// - reset while request or status low
// - release done, stop load clock, init after high
`timescale 1ns/1ps
module cics_device #(
  parameter int unsigned INIT_TOTAL = cics_pkg::INIT_CYCLES,
  parameter int unsigned RESTART_TMO = cics_pkg::RESTART_TMO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  cics_link_if.dev link,
  input wire logic [1:0] scheme_select,
  input wire logic use_usr_clk,
  input wire logic init_done_en,
  input wire logic auto_restart,
  input wire logic frame_first,
  input wire logic load_last,
  input wire logic frame_error,
  output logic serial_load_clock_en,
  output logic active_master,
  output logic user_mode,
  output logic pullups_en,
  output logic io_oe_allowed
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_active(input logic [1:0] sel);
    return sel == cics_pkg::SCHEME_ACTIVE;
  endfunction
  // states in which the load-side outputs fall back to their reset levels
  function automatic logic quiet_state(input cics_pkg::cics_state_t s);
    return s == cics_pkg::ST_RESET || s == cics_pkg::ST_ERROR;
  endfunction
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rq_s, st_s, dn_s, uc_s, ce_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_s <= 2'h0;
      st_s <= 2'h0;
      dn_s <= 2'h0;
      uc_s <= 2'h0;
      // chain input idles deselected until seen
      ce_s <= 2'h3;
    end else begin
      rq_s <= {rq_s[0], link.reconf_req_n};
      st_s <= {st_s[0], link.status_line};
      dn_s <= {dn_s[0], link.done_line};
      uc_s <= {uc_s[0], link.usr_clk};
      ce_s <= {ce_s[0], link.chain_enable_in_n};
    end
  end
  logic rq, st, dn, uc_q;
  assign rq = rq_s[1];
  assign st = st_s[1];
  assign dn = dn_s[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uc_q <= 1'b0;
    else uc_q <= uc_s[1];
  end
  // ----------------------------------------------------------------
  // init clock tick: internal every cycle, user clock on its rising edges
  // ----------------------------------------------------------------
  // user clock is oversampled: it must not exceed half of pclk
  logic init_tick;
  assign init_tick = use_usr_clk ? (uc_s[1] & ~uc_q) : 1'b1;
  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  cics_pkg::cics_state_t state_q;
  logic [cics_pkg::CNT_W-1:0] cnt_q;
  logic status_oe_q, done_oe_q, init_oe_q, ceo_q, cs_q, sclk_q, user_q;
  logic held_reset;
  assign held_reset = ~rq;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cics_pkg::ST_RESET;
    end else if (held_reset) begin
      state_q <= cics_pkg::ST_RESET;
    end else begin
      unique case (state_q)
        cics_pkg::ST_RESET: begin
          // status released by us and seen high on the shared line
          if (!status_oe_q && st && !ce_s[1]) state_q <= cics_pkg::ST_LOAD;
        end
        cics_pkg::ST_LOAD: begin
          if (frame_error || !st) state_q <= cics_pkg::ST_ERROR;
          else if (load_last) state_q <= cics_pkg::ST_WAIT_DONE;
        end
        cics_pkg::ST_WAIT_DONE: begin
          if (!st) state_q <= cics_pkg::ST_ERROR;
          else if (dn) state_q <= cics_pkg::ST_INIT;
        end
        cics_pkg::ST_INIT: begin
          if (!st) state_q <= cics_pkg::ST_ERROR;
          else if (init_tick && cnt_q == cics_pkg::CNT_W'(INIT_TOTAL - 1))
            state_q <= cics_pkg::ST_USER;
        end
        // user mode is left only through a reconfigure request
        cics_pkg::ST_USER: state_q <= cics_pkg::ST_USER;
        cics_pkg::ST_ERROR: begin
          if (auto_restart && cnt_q == cics_pkg::CNT_W'(RESTART_TMO - 1))
            state_q <= cics_pkg::ST_RESET;
        end
        default: state_q <= cics_pkg::ST_RESET;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // shared counter: init cycles or restart timeout
  // one counter serves both, since init and error never overlap
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= '0;
    else if (held_reset) cnt_q <= '0;
    else if (state_q == cics_pkg::ST_INIT) begin
      if (init_tick) cnt_q <= cnt_q + 1'b1;
    end else if (state_q == cics_pkg::ST_ERROR) begin
      if (auto_restart) cnt_q <= cnt_q + 1'b1;
    end else cnt_q <= '0;
  end
  // ----------------------------------------------------------------
  // open-drain drivers
  // ----------------------------------------------------------------
  // high enable pulls the shared line low; the pull-up does the rest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_oe_q <= 1'b1;
    else if (held_reset) status_oe_q <= 1'b1;
    else if (state_q == cics_pkg::ST_ERROR) status_oe_q <= 1'b1;
    else if (frame_error && state_q == cics_pkg::ST_LOAD) status_oe_q <= 1'b1;
    else status_oe_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_oe_q <= 1'b1;
    else if (held_reset) done_oe_q <= 1'b1;
    else if (quiet_state(state_q)) done_oe_q <= 1'b1;
    else if (state_q == cics_pkg::ST_LOAD) done_oe_q <= ~load_last | frame_error;
    else done_oe_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) init_oe_q <= 1'b0;
    else if (held_reset || state_q == cics_pkg::ST_RESET) init_oe_q <= 1'b0;
    else if (state_q == cics_pkg::ST_USER) init_oe_q <= 1'b0;
    else if (init_done_en && frame_first) init_oe_q <= 1'b1;
  end
  // ----------------------------------------------------------------
  // chain, flash select, load clock, user mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ceo_q <= 1'b1;
    else if (held_reset || quiet_state(state_q))
      ceo_q <= 1'b1;
    else if (state_q == cics_pkg::ST_LOAD && load_last && !frame_error) ceo_q <= 1'b0;
    // held at ground until a request or an error state; never handed to user logic
  end
  assign link.chain_enable_out_n = ceo_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cs_q <= 1'b1;
    // deselect at error start doubles as the flash reset pulse
    else if (state_q == cics_pkg::ST_ERROR && auto_restart &&
             cnt_q < cics_pkg::CNT_W'(cics_pkg::CS_PULSE_CYC))
      cs_q <= 1'b1;
    else cs_q <= ~(state_q == cics_pkg::ST_LOAD && is_active(scheme_select));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    // stops on the last bit so the flash sees no extra edge
    else sclk_q <= state_q == cics_pkg::ST_LOAD && !load_last &&
                   is_active(scheme_select);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) user_q <= 1'b0;
    // one edge behind the state so the outputs leave a flip-flop
    else user_q <= state_q == cics_pkg::ST_USER && !held_reset;
  end
  logic master_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) master_q <= 1'b0;
    else master_q <= is_active(scheme_select);
  end
  assign link.status_oe = status_oe_q;
  assign link.done_oe = done_oe_q;
  assign link.init_done_oe = init_oe_q;
  assign link.flash_cs_n = cs_q;
  assign serial_load_clock_en = sclk_q;
  assign active_master = master_q;
  assign user_mode = user_q;
  assign pullups_en = ~user_q;
  assign io_oe_allowed = user_q;
endmodule

/* cics_controller.sv */
/*
  cics_controller: external controller end, an apb slave driving the reconfigure request
  and user start-up clock, and reporting the shared lines. assumes one pclk domain.
*/
`timescale 1ns/1ps
module cics_controller #(
  parameter int unsigned RECONF_LOW = cics_pkg::RECONF_LOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  cics_link_if.ctl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------------
  logic [1:0] st_s, dn_s, id_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_s <= 2'h0;
      dn_s <= 2'h0;
      id_s <= 2'h0;
    end else begin
      st_s <= {st_s[0], link.status_line};
      dn_s <= {dn_s[0], link.done_line};
      id_s <= {id_s[0], link.init_done_line};
    end
  end
  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  logic wr, rd;
  logic start_q, run_q, busy_q, uclk_q, rdy_q, err_q;
  logic [31:0] rdata_q;
  logic [cics_pkg::CNT_W-1:0] low_q;
  assign wr = psel && !penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= cics_pkg::APB_ZERO;
    end else begin
      rdy_q <= psel && !penable;
      err_q <= psel && !penable && paddr != cics_pkg::REG_CTRL && paddr != cics_pkg::REG_STAT;
      rdata_q <= cics_pkg::APB_ZERO;
      if (rd && paddr == cics_pkg::REG_CTRL) begin
        rdata_q[cics_pkg::CTRL_USRCLK_RUN] <= run_q;
      end
      if (rd && paddr == cics_pkg::REG_STAT) begin
        rdata_q[cics_pkg::STAT_STATUS] <= st_s[1];
        rdata_q[cics_pkg::STAT_DONE] <= dn_s[1];
        rdata_q[cics_pkg::STAT_INIT_DONE] <= id_s[1];
        rdata_q[cics_pkg::STAT_RECONF_BUSY] <= busy_q;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      start_q <= wr && paddr == cics_pkg::REG_CTRL && pwdata[cics_pkg::CTRL_RECONF];
      if (wr && paddr == cics_pkg::REG_CTRL) run_q <= pwdata[cics_pkg::CTRL_USRCLK_RUN];
    end
  end
  // ----------------------------------------------------------------
  // reconfigure pulse, at least two microseconds low
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      low_q <= '0;
    end else if (start_q && !busy_q) begin
      busy_q <= 1'b1;
      low_q <= '0;
    end else if (busy_q) begin
      if (low_q == cics_pkg::CNT_W'(RECONF_LOW - 1)) busy_q <= 1'b0;
      low_q <= low_q + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // user start-up clock: half pclk, runs while enabled
  // ----------------------------------------------------------------
  // keeping it running through status low is left to software holding run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uclk_q <= 1'b0;
    else if (run_q) uclk_q <= ~uclk_q;
    else uclk_q <= 1'b0;
  end
  assign link.reconf_req_n = ~busy_q;
  assign link.usr_clk = uclk_q;
  assign link.status_ext_oe = 1'b0;
  assign link.done_ext_oe = 1'b0;
  assign link.chain_enable_in_n = 1'b0;
  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
endmodule

/* cics_link_chk.sv */
/*
  cics_link_chk: assertions on the link that joins device and controller.
  assumes one pclk domain; inputs are the link signals, connected by name.
*/
`timescale 1ns/1ps
module cics_link_chk #(
  parameter int unsigned INIT_TOTAL = cics_pkg::INIT_CYCLES,
  parameter int unsigned RECONF_LOW = cics_pkg::RECONF_LOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reconf_req_n,
  input wire logic status_oe,
  input wire logic done_oe,
  input wire logic init_done_oe,
  input wire logic chain_enable_out_n,
  input wire logic done_line
);
  logic [15:0] low_cnt_q;
  logic [15:0] init_cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= reconf_req_n ? 16'h0000 : low_cnt_q + 16'h0001;
    end
  end
  // saturation not needed: init never runs near 16 bits of cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_q <= 16'h0000;
    end else begin
      init_cnt_q <= done_line ? init_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reconf_width: assert property (
    $rose(reconf_req_n) |-> low_cnt_q >= RECONF_LOW) else $error("reconfigure pulse too short");
  a_reset_hold: assert property (
    !reconf_req_n [*6] |-> status_oe && done_oe && chain_enable_out_n)
    else $error("device not held in reset");
  a_status_release: assert property (
    $fell(status_oe) |-> reconf_req_n && $past(reconf_req_n, 2))
    else $error("status released during request");
  a_error_no_done: assert property (
    status_oe |-> done_oe) else $error("done released with status low");
  a_chain_handoff: assert property (
    $fell(chain_enable_out_n) |-> $fell(done_oe)) else $error("chain out not tied to load end");
  a_chain_keep: assert property (
    !chain_enable_out_n && !status_oe |=> !chain_enable_out_n || status_oe)
    else $error("chain out left ground");
  a_done_release: assert property (
    $fell(done_oe) |-> !status_oe && reconf_req_n) else $error("done released out of load");
  a_init_count: assert property (
    $fell(init_done_oe) && !status_oe |-> init_cnt_q >= INIT_TOTAL)
    else $error("init ended early");
endmodule

/* tb_config_init_chain_sequencer.sv */
/*
  tb_config_init_chain_sequencer: both ends joined by the link; apb tasks drive the
  controller, load events drive the device. assumes shortened init and restart counts.
*/
`timescale 1ns/1ps
module tb_config_init_chain_sequencer;
  localparam int unsigned IT = 5;
  localparam int unsigned RT = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic use_usr = 1'b0;
  logic arst = 1'b0;
  logic ff = 1'b0;
  logic ll = 1'b0;
  logic fe = 1'b0;
  logic slce, am, um, pu, ioe, er;
  logic [31:0] rd;
  int n_fail = 0;
  int compares = 0;
  int n;
  cics_link_if link ();
  cics_device #(.INIT_TOTAL(IT), .RESTART_TMO(RT)) cics_device_inst (.pclk(pclk),
    .presetn(presetn), .link(link), .scheme_select(cics_pkg::SCHEME_ACTIVE),
    .use_usr_clk(use_usr), .init_done_en(1'b1), .auto_restart(arst), .frame_first(ff),
    .load_last(ll), .frame_error(fe), .serial_load_clock_en(slce), .active_master(am),
    .user_mode(um), .pullups_en(pu), .io_oe_allowed(ioe));
  cics_controller cics_controller_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cics_link_chk #(.INIT_TOTAL(IT)) cics_link_chk_inst (.pclk(pclk), .presetn(presetn),
    .reconf_req_n(link.reconf_req_n), .status_oe(link.status_oe), .done_oe(link.done_oe),
    .init_done_oe(link.init_done_oe), .chain_enable_out_n(link.chain_enable_out_n),
    .done_line(link.done_line));
  always #50 pclk = ~pclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge pclk);
    {ff, ll, fe} <= v;
    @(posedge pclk);
    {ff, ll, fe} <= 3'h0;
  endtask
  task automatic wait_line(input logic want);
    n = 0;
    while (link.status_line !== want && n < 100) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic wait_user;
    n = 0;
    while (um !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, cics_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h0000_0005);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], er}, 32'h0000_0001);
    @(negedge pclk);
    chk(32'({am, slce, link.chain_enable_out_n}), 32'h7);
    pulse(3'h4);
    @(negedge pclk);
    chk(32'(link.init_done_line), 32'h0);
    pulse(3'h2);
    wait_user;
    chk(32'(n >= IT + 2 && n <= IT + 8), 32'h1);
    chk(32'({pu, ioe, slce, link.init_done_line, link.done_line, link.chain_enable_out_n}),
        32'h16);
    // reconfigure from user mode
    apb(1'b1, cics_pkg::REG_CTRL, 32'h0000_0001);
    repeat (6) @(posedge pclk);
    apb(1'b0, cics_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h0000_000C);
    chk(32'({um, pu, ioe, link.chain_enable_out_n}), 32'h5);
    wait_line(1'b1);
    chk(32'(link.status_line), 32'h1);
    // frame error with auto-restart
    @(posedge pclk);
    arst <= 1'b1;
    repeat (4) @(posedge pclk);
    pulse(3'h1);
    @(negedge pclk);
    @(negedge pclk);
    chk(32'({link.status_line, link.done_line, link.flash_cs_n}), 32'h1);
    wait_line(1'b1);
    chk(32'(n + 1 >= RT && n <= RT + 6), 32'h1);
    // frame error without auto-restart: only the host recovers
    @(posedge pclk);
    arst <= 1'b0;
    repeat (4) @(posedge pclk);
    pulse(3'h1);
    repeat (3 * RT) @(negedge pclk);
    chk(32'(link.status_line), 32'h0);
    apb(1'b1, cics_pkg::REG_CTRL, 32'h0000_0001);
    wait_line(1'b0);
    wait_line(1'b1);
    chk(32'(n < 100), 32'h1);
    chk(32'(link.status_line), 32'h1);
    // user start-up clock withheld, then supplied
    @(posedge pclk);
    use_usr <= 1'b1;
    repeat (4) @(posedge pclk);
    pulse(3'h2);
    repeat (4 * IT) @(negedge pclk);
    chk(32'({link.done_line, um}), 32'h2);
    apb(1'b1, cics_pkg::REG_CTRL, 32'h0000_0002);
    wait_user;
    chk(32'(n >= IT && n < 200), 32'h1);
    apb(1'b0, cics_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h0000_0007);
    apb(1'b0, cics_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0000_0002);
    finish_test;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    finish_test;
  end
endmodule
